// File: inc/hpbp_pkg.sv
// Package for the host parallel bus port: widths, timing counts, port bundles.
// Assumes one system clock at 200 MHz; host pins already synchronous to it.
package hpbp_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int CHAN_N = 8;

   // Reset values
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   // Access-done delay after the strobe is seen active
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int ACK_DELAY_NS   = 20;
   localparam int ACK_DELAY_CYC  = (ACK_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [3:0] ACK_CNT_LAST = 4'(ACK_DELAY_CYC - 1);

   // Framing mode per channel after reset
   typedef enum logic [1:0] {
      HPBP_FRM_T1 = 2'h1,
      HPBP_FRM_E1 = 2'h2
   } hpbp_frame_mode_t;

   // Access sequencer states
   typedef enum logic [3:0] {
      HPBP_IDLE = 4'h1,
      HPBP_WAIT = 4'h2,
      HPBP_DONE = 4'h4,
      HPBP_HOLD = 4'h8
   } hpbp_state_t;

   // Host pin bundle as seen by the device
   typedef struct packed {
      logic              select_n;
      logic              read_n_or_rnw;
      logic              store_or_data_strobe_pin;
      logic              latch_enable_or_addr_strobe_pin;
      logic [ADDR_W-1:0] host_register_select_bus;
      logic [DATA_W-1:0] host_data_in;
   } hpbp_host_in_t;

   // Internal register-file access
   typedef struct packed {
      logic              wr_en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } hpbp_reg_wr_t;

endpackage : hpbp_pkg

// File: design/hpbp_regmem.sv
// Directly addressed register store behind the host port.
// Assumes one clock, synchronous reset is not applied to contents.
`timescale 1ns/1ps
`default_nettype none
module hpbp_regmem #(
   parameter int ADDR_W = hpbp_pkg::ADDR_W,
   parameter int DATA_W = hpbp_pkg::DATA_W
) (
   // Clock
   input  wire logic              clk,
   // Write side
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   // Read side, registered
   input  wire logic [ADDR_W-1:0] rd_addr,
   output      logic [DATA_W-1:0] rd_data
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule : hpbp_regmem
`default_nettype wire

// File: design/hpbp_top.sv
// Host parallel bus port: two bus styles chosen by a strap, register access.
// Assumes host pins synchronous to CLK_SYS; pads resolve data and ack enables.
`timescale 1ns/1ps
`default_nettype none

module hpbp_top #(
   parameter int ADDR_W = hpbp_pkg::ADDR_W,
   parameter int DATA_W = hpbp_pkg::DATA_W,
   parameter int CHAN_N = hpbp_pkg::CHAN_N
) (
   // Clock and reset
   input  wire logic                           CLK_SYS,
   input  wire logic                           SRST,
   // Straps
   input  wire logic                           HOST_PROTOCOL_STRAP,
   input  wire logic                           LINE_STANDARD_SELECT,
   // Host control pins
   input  wire logic                           SELECT_N,
   input  wire logic                           READ_N_OR_RNW,
   input  wire logic                           STORE_OR_DATA_STROBE_PIN,
   input  wire logic                           LATCH_ENABLE_OR_ADDR_STROBE_PIN,
   input  wire logic [ADDR_W-1:0]              HOST_REGISTER_SELECT_BUS,
   // Host data bus, three signals
   input  wire logic [DATA_W-1:0]              HOST_DATA_BUS_I,
   output      logic [DATA_W-1:0]              HOST_DATA_BUS_O,
   output      logic                           HOST_DATA_BUS_OE_N,
   // Access-done / transfer acknowledge pin
   output      logic                           ACCESS_DONE_O,
   output      logic                           ACCESS_DONE_OE_N,
   // Per-channel framing mode
   output      hpbp_pkg::hpbp_frame_mode_t [CHAN_N-1:0] CHAN_FRAME_MODE
);

   // Write carrier uses package widths, so only those widths are served
   if (ADDR_W != hpbp_pkg::ADDR_W || DATA_W != hpbp_pkg::DATA_W || CHAN_N < 1) begin : g_bad_params
      $error("hpbp_top: unsupported parameter values");
   end

   hpbp_pkg::hpbp_state_t    state_reg;
   hpbp_pkg::hpbp_state_t    state_next;
   logic                     split_mode_reg;
   logic [3:0]               cnt_reg;
   logic                     strb_prev_reg;
   logic                     acc_active;
   logic                     rd_strobe;
   logic                     wr_strobe;
   logic                     wr_rise;
   logic                     is_read;
   logic [DATA_W-1:0]        rd_data;
   logic [ADDR_W-1:0]        addr_reg;
   logic [DATA_W-1:0]        wdata_reg;
   hpbp_pkg::hpbp_reg_wr_t   wr_req;

   // Strap caught at reset so a strap glitch mid-run cannot flip styles
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         split_mode_reg <= HOST_PROTOCOL_STRAP;
      end
   end

   // Per-channel default framing mode
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         for (int i = 0; i < CHAN_N; i++) begin
            CHAN_FRAME_MODE[i] <= LINE_STANDARD_SELECT ? hpbp_pkg::HPBP_FRM_T1
                                                       : hpbp_pkg::HPBP_FRM_E1;
         end
      end
   end

   // Access qualifiers for each bus style
   always_comb begin
      if (split_mode_reg) begin
         acc_active = !SELECT_N;
         rd_strobe  = !SELECT_N && !READ_N_OR_RNW;
         wr_strobe  = !SELECT_N && !STORE_OR_DATA_STROBE_PIN;
         is_read    = !READ_N_OR_RNW;
      end else begin
         acc_active = !LATCH_ENABLE_OR_ADDR_STROBE_PIN;
         rd_strobe  = acc_active && READ_N_OR_RNW && !STORE_OR_DATA_STROBE_PIN;
         wr_strobe  = acc_active && !READ_N_OR_RNW && !STORE_OR_DATA_STROBE_PIN;
         is_read    = READ_N_OR_RNW;
      end
   end

   // Store strobe edge tracking: commit on its rising edge
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         strb_prev_reg <= 1'b0;
      end else begin
         strb_prev_reg <= wr_strobe;
      end
   end

   assign wr_rise = strb_prev_reg && !wr_strobe
                    && (split_mode_reg ? !SELECT_N : acc_active);

   // Address held through the access for decode
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         addr_reg <= '0;
      end else if (acc_active) begin
         addr_reg <= HOST_REGISTER_SELECT_BUS;
      end
   end

   // Data sampled while the strobe is low, so the value at the edge is kept
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         wdata_reg <= hpbp_pkg::DATA_RST;
      end else if (wr_strobe) begin
         wdata_reg <= HOST_DATA_BUS_I;
      end
   end

   // One driver for the whole carrier
   assign wr_req = '{wr_en: wr_rise, addr: addr_reg, wdata: wdata_reg};

   hpbp_regmem #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_regmem (
      .clk     (CLK_SYS),
      .wr_en   (wr_req.wr_en),
      .wr_addr (wr_req.addr),
      .wr_data (wr_req.wdata),
      .rd_addr (HOST_REGISTER_SELECT_BUS),
      .rd_data (rd_data)
   );

   // Read data from a flip-flop; bus released outside reads
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         HOST_DATA_BUS_O    <= hpbp_pkg::DATA_RST;
         HOST_DATA_BUS_OE_N <= 1'b1;
      end else begin
         HOST_DATA_BUS_O    <= rd_data;
         HOST_DATA_BUS_OE_N <= !rd_strobe;
      end
   end

   // Access sequencer: fixed delay after strobe seen, then done until release
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         hpbp_pkg::HPBP_IDLE: begin
            if (rd_strobe || wr_strobe) begin
               state_next = hpbp_pkg::HPBP_WAIT;
            end
         end
         hpbp_pkg::HPBP_WAIT: begin
            if (!acc_active) begin
               state_next = hpbp_pkg::HPBP_IDLE;
            end else if (cnt_reg == hpbp_pkg::ACK_CNT_LAST) begin
               state_next = hpbp_pkg::HPBP_DONE;
            end
         end
         hpbp_pkg::HPBP_DONE: begin
            if (!acc_active) begin
               state_next = hpbp_pkg::HPBP_IDLE;
            end else if (!(rd_strobe || wr_strobe) && !is_read) begin
               state_next = hpbp_pkg::HPBP_HOLD;
            end
         end
         hpbp_pkg::HPBP_HOLD: begin
            if (!acc_active) begin
               state_next = hpbp_pkg::HPBP_IDLE;
            end
         end
         default: state_next = hpbp_pkg::HPBP_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         state_reg <= hpbp_pkg::HPBP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST || state_reg != hpbp_pkg::HPBP_WAIT) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // Done pin: split style floats when deselected, address style always driven
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ACCESS_DONE_O    <= 1'b1;
         ACCESS_DONE_OE_N <= 1'b1;
      end else if (split_mode_reg) begin
         ACCESS_DONE_OE_N <= SELECT_N;
         ACCESS_DONE_O    <= (state_next == hpbp_pkg::HPBP_DONE
                             || state_next == hpbp_pkg::HPBP_HOLD);
      end else begin
         ACCESS_DONE_OE_N <= 1'b0;
         ACCESS_DONE_O    <= !(state_next == hpbp_pkg::HPBP_DONE
                              || state_next == hpbp_pkg::HPBP_HOLD);
      end
   end

endmodule : hpbp_top
`default_nettype wire

// File: tb/hpbp_top_chk.sv
// Port checker for the host parallel bus port, both bus styles.
// Assumes the style strap and line select stay steady while SRST is high.
`timescale 1ns/1ps
`default_nettype none
module hpbp_top_chk #(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 8,
   parameter int CHAN_N = 8
) (
   // Clock, reset, straps
   input wire logic                                    CLK_SYS,
   input wire logic                                    SRST,
   input wire logic                                    HOST_PROTOCOL_STRAP,
   input wire logic                                    LINE_STANDARD_SELECT,
   // Host pins
   input wire logic                                    SELECT_N,
   input wire logic                                    READ_N_OR_RNW,
   input wire logic                                    STORE_OR_DATA_STROBE_PIN,
   input wire logic                                    LATCH_ENABLE_OR_ADDR_STROBE_PIN,
   input wire logic                                    HOST_DATA_BUS_OE_N,
   input wire logic                                    ACCESS_DONE_O,
   input wire logic                                    ACCESS_DONE_OE_N,
   input wire hpbp_pkg::hpbp_frame_mode_t [CHAN_N-1:0] CHAN_FRAME_MODE
);
   logic                       split_reg;
   hpbp_pkg::hpbp_frame_mode_t mode_reg;
   logic                       rd_act;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   // Straps are only meaningful while reset is held
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         split_reg <= HOST_PROTOCOL_STRAP;
         mode_reg  <= LINE_STANDARD_SELECT ? hpbp_pkg::HPBP_FRM_T1 : hpbp_pkg::HPBP_FRM_E1;
      end
   end

   assign rd_act = split_reg ? (!SELECT_N && !READ_N_OR_RNW)
                 : (!LATCH_ENABLE_OR_ADDR_STROBE_PIN && READ_N_OR_RNW
                    && !STORE_OR_DATA_STROBE_PIN);

   split_float_a: assert property (split_reg && SELECT_N
      && $past(SELECT_N) |-> ACCESS_DONE_OE_N)
      else $error("done pin driven while deselected");
   split_done_a: assert property (split_reg && $fell(SELECT_N)
      && !(STORE_OR_DATA_STROBE_PIN && READ_N_OR_RNW)
      |=> ##1 (!ACCESS_DONE_OE_N && !ACCESS_DONE_O)[*2] ##[1:4] ACCESS_DONE_O)
      else $error("split access done timing wrong");
   split_hold_a: assert property (split_reg && !SELECT_N && ACCESS_DONE_O && !ACCESS_DONE_OE_N
      ##1 !SELECT_N |-> ACCESS_DONE_O && !ACCESS_DONE_OE_N)
      else $error("split done dropped early");
   ack_idle_a: assert property (!split_reg && LATCH_ENABLE_OR_ADDR_STROBE_PIN
      && $past(LATCH_ENABLE_OR_ADDR_STROBE_PIN) |-> ACCESS_DONE_O)
      else $error("acknowledge low while idle");
   ack_time_a: assert property (!split_reg && $fell(LATCH_ENABLE_OR_ADDR_STROBE_PIN)
      && !STORE_OR_DATA_STROBE_PIN |=> ##1 ACCESS_DONE_O[*2] ##[1:4] !ACCESS_DONE_O)
      else $error("acknowledge timing wrong");
   rd_on_a: assert property (rd_act[*3] |-> !HOST_DATA_BUS_OE_N)
      else $error("data bus not driven on read");
   rd_off_a: assert property (!rd_act[*3] |-> HOST_DATA_BUS_OE_N)
      else $error("data bus driven outside read");
   frame_mode_a: assert property (CHAN_FRAME_MODE == {CHAN_N{mode_reg}})
      else $error("framing mode wrong after reset");
endmodule : hpbp_top_chk
`default_nettype wire

bind hpbp_top hpbp_top_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CHAN_N(CHAN_N)) chk (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .HOST_PROTOCOL_STRAP(HOST_PROTOCOL_STRAP),
   .LINE_STANDARD_SELECT(LINE_STANDARD_SELECT), .SELECT_N(SELECT_N),
   .READ_N_OR_RNW(READ_N_OR_RNW), .STORE_OR_DATA_STROBE_PIN(STORE_OR_DATA_STROBE_PIN),
   .LATCH_ENABLE_OR_ADDR_STROBE_PIN(LATCH_ENABLE_OR_ADDR_STROBE_PIN),
   .HOST_DATA_BUS_OE_N(HOST_DATA_BUS_OE_N), .ACCESS_DONE_O(ACCESS_DONE_O),
   .ACCESS_DONE_OE_N(ACCESS_DONE_OE_N), .CHAN_FRAME_MODE(CHAN_FRAME_MODE));

// File: tb/hpbp_host_model.sv
// Host processor model for either bus style of the port.
// Assumes split equals the strap level the port captured at its last reset.
`timescale 1ns/1ps
`default_nettype none
module hpbp_host_model (
   // Clock and style
   input  wire logic                    clk,
   input  wire logic                    split,
   // Pins toward the port
   output      hpbp_pkg::hpbp_host_in_t pins,
   input  wire logic [7:0]              dout,
   input  wire logic                    dout_oe_n,
   input  wire logic                    done_o,
   input  wire logic                    done_oe_n
);
   logic        sel_n = 1'b1, rd_n = 1'b1, st_n = 1'b1, astb_n = 1'b1, own = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0]  drv = 8'h00;

   // No pull-up on the data bus: released lines show the inverse of the last value
   assign pins = '{sel_n, rd_n, st_n, astb_n, addr, !dout_oe_n ? dout : (own ? drv : ~drv)};

   task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
      int n;
      @(posedge clk);
      #1;
      addr = a;
      drv = d;
      own = wr;
      rd_n = split ? wr : !wr;
      st_n = split ? !wr : 1'b0;
      sel_n = !split;
      astb_n = split;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(done_oe_n === 1'b0 && done_o === split) && n < 40);
      q = dout;
      ok = (n < 40);
      #1;
      st_n = 1'b1;
      rd_n = split ? 1'b1 : rd_n;
      @(posedge clk);
      #1;
      sel_n = 1'b1;
      astb_n = 1'b1;
      own = 1'b0;
      repeat (2) @(posedge clk);
   endtask : acc

   // Store strobe with the device left deselected
   task automatic stray(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      drv = d;
      own = 1'b1;
      st_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      st_n = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      own = 1'b0;
   endtask : stray
endmodule : hpbp_host_model
`default_nettype wire

// File: tb/host_parallel_bus_port_test.sv
// Self-checking bench for the host parallel bus port, both strap settings.
// Assumes the host model and the bound port checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module host_parallel_bus_port_test;
   logic                             clk_sys = 1'b0, srst = 1'b1, strap = 1'b1, line_sel = 1'b1;
   hpbp_pkg::hpbp_host_in_t          pins;
   logic [7:0]                       dout, q;
   logic                             doe_n, done_o, done_oe_n, ok;
   hpbp_pkg::hpbp_frame_mode_t [7:0] mode;
   int                               error_cnt = 0, tests_run = 0;

   hpbp_top dut (.CLK_SYS(clk_sys), .SRST(srst), .HOST_PROTOCOL_STRAP(strap),
      .LINE_STANDARD_SELECT(line_sel), .SELECT_N(pins.select_n),
      .READ_N_OR_RNW(pins.read_n_or_rnw), .STORE_OR_DATA_STROBE_PIN(pins.store_or_data_strobe_pin),
      .LATCH_ENABLE_OR_ADDR_STROBE_PIN(pins.latch_enable_or_addr_strobe_pin),
      .HOST_REGISTER_SELECT_BUS(pins.host_register_select_bus),
      .HOST_DATA_BUS_I(pins.host_data_in),
      .HOST_DATA_BUS_O(dout), .HOST_DATA_BUS_OE_N(doe_n), .ACCESS_DONE_O(done_o),
      .ACCESS_DONE_OE_N(done_oe_n), .CHAN_FRAME_MODE(mode));
   hpbp_host_model host (.clk(clk_sys), .split(strap), .pins(pins), .dout(dout),
      .dout_oe_n(doe_n), .done_o(done_o), .done_oe_n(done_oe_n));

   task automatic cmp(input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp

   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic restart(input logic s, input logic l);
      @(posedge clk_sys);
      #1;
      srst = 1'b1;
      strap = s;
      line_sel = l;
      repeat (10) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : restart

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      host.acc(1'b1, a, d, q, ok);
      cmp(16'h0001, {15'h0000, ok});
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      host.acc(1'b0, a, 8'h00, q, ok);
      cmp({8'h01, e}, {7'h00, ok, q});
   endtask : rd

   task automatic t_split();
      restart(1'b1, 1'b1);
      cmp({8{hpbp_pkg::HPBP_FRM_T1}}, mode);
      wr(12'h000, 8'hA5);
      wr(12'hFFF, 8'h5A);
      host.stray(12'h000, 8'h3C);
      rd(12'h000, 8'hA5);
      rd(12'hFFF, 8'h5A);
      cmp(16'h0001, {15'h0000, doe_n});
   endtask : t_split

   task automatic t_addr();
      restart(1'b0, 1'b0);
      cmp({8{hpbp_pkg::HPBP_FRM_E1}}, mode);
      wr(12'h001, 8'hC3);
      wr(12'h002, 8'h3C);
      rd(12'h001, 8'hC3);
      rd(12'h002, 8'h3C);
      rd(12'h000, 8'hA5);
      cmp(16'h0002, {14'h0000, done_o, done_oe_n});
   endtask : t_addr

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   // About 120 cycles of traffic; twenty microseconds leaves wide margin
   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end

   initial begin
      t_split();
      t_addr();
      end_sim();
   end
endmodule : host_parallel_bus_port_test
`default_nettype wire
